// ### dv/rispc_ref_src.sv
// reference source model: toggles every HALF core cycles while running
`timescale 1ns/1ps
module rispc_ref_src #(
  parameter int HALF = 3
) (
  input  wire logic core_clk,
  input  wire logic run,
  output logic      ref_level
);
  int   cnt = 0;
  logic lvl = 1'b0;
  // a stopped source freezes at its last level, like a dead oscillator
  always @(posedge core_clk) begin
    if (run) begin
      cnt = (cnt + 1) % HALF;
      if (cnt == 0) lvl <= ~lvl; // both sources share HALF, same rate
    end
  end
  assign ref_level = lvl;
endmodule

// ### dv/rispc_tb_top.sv
// testbench for the reference select block
`timescale 1ns/1ps
module rispc_tb_top;
  import rispc_pkg::*;
  localparam int LOSS = 10;
  logic        core_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [6:0]  reg_addr = 7'h00;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata, rd_val, chdiv;
  logic [1:0]  ref_choice_pin = RISPC_PIN_LOW;
  logic        pri_run = 1'b0, sec_run = 1'b0, pri_ref, sec_ref;
  logic        use_sec, gate_open, lost, outs_en, sec_path, doubler, out_src;
  logic [2:0]  rdiv;
  logic [11:0] fint;
  logic [21:0] fnum, fden;
  logic [4:0]  presc;
  logic [3:0]  post, itype;
  logic [5:0]  iswitch;
  int          n_errors = 0, checked = 0;

  always #4 core_clk = ~core_clk;

  rispc_ref_src #(.HALF(3)) u_rispc_ref_src_p (.core_clk(core_clk), .run(pri_run), .ref_level(pri_ref));
  rispc_ref_src #(.HALF(3)) u_rispc_ref_src_s (.core_clk(core_clk), .run(sec_run), .ref_level(sec_ref));
  rispc_top #(.LOSS_CYC(LOSS)) u_rispc_top (
    .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .primary_reference(pri_ref),
    .secondary_reference(sec_ref), .ref_choice_pin(ref_choice_pin), .ref_use_secondary(use_sec),
    .ref_gate_open(gate_open), .both_refs_lost(lost), .pll_outputs_enable(outs_en),
    .secondary_path_enable(sec_path), .ref_div_m1(rdiv), .doubler_en(doubler), .fb_integer(fint),
    .fb_numerator(fnum), .fraction_denominator(fden), .prescale_m1(presc), .post_divider(post),
    .channel_divider_m1(chdiv), .output_source_selector(out_src), .inbuf_switches(iswitch), .inbuf_type(itype));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // write, read back; outputs have settled by the time the read returns
  task automatic wrb(input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
    wr(a, d);
    rd(a, rd_val);
    chk("readback", e, rd_val);
  endtask
  function automatic logic pick(input int w);
    return w == 0 ? use_sec : (w == 1 ? lost : (w == 2 ? sec_path : outs_en));
  endfunction
  task automatic wait_bit(input int w, input logic exp, input string what);
    for (int i = 0; i < 80 && pick(w) !== exp; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk(what, exp, pick(w));
  endtask

  task automatic t_reset();
    chk("fb_integer", RISPC_RST_INT, fint);
    chk("denominator", RISPC_RST_DEN, fden);
    chk("post_divider", RISPC_RST_POST, post);
    rd(RISPC_R_SWCTL, rd_val);
    chk("keep-alive", RISPC_RST_SWCTL, rd_val);
    rd(7'h7B, rd_val);
    chk("last register", 8'h00, rd_val);
  endtask
  task automatic t_cfg();
    logic [7:0] bufs [4] = '{8'h0F, 8'h30, 8'h0C, 8'h00};
    logic [3:0] last = 4'h2;
    wrb(RISPC_R_PLLDIV_A, 8'h0F, 8'h0F);
    chk("ref_div_m1", 3'h7, rdiv);
    chk("doubler_en", 1'b1, doubler);
    wrb(RISPC_R_PRESC, 8'h1F, 8'h1F);
    chk("prescale_m1", 5'h1F, presc);
    wrb(RISPC_R_CHANNEL_DIVIDER, 8'hFF, 8'hFF);
    chk("channel divider", 8'hFF, chdiv);
    wrb(RISPC_R_OUTSEL, 8'h01, 8'h01);
    chk("output source", 1'b1, out_src);
    for (int p = 0; p < 10; p++) begin
      if (p >= 2 && p <= 8) last = p[3:0];
      wrb(RISPC_R_POSTDIV, p[7:0], {4'h0, last});
      chk("post_divider", last, post);
    end
    wrb(RISPC_R_INT_HI, 8'h0F, 8'h0F);
    wrb(RISPC_R_INT_LO, 8'hFF, 8'hFF);
    chk("fb_integer", 12'hFFF, fint);
    wrb(RISPC_R_INT_LO, 8'h00, 8'h00);
    wrb(RISPC_R_INT_HI, 8'h00, 8'h0F);
    chk("fb_integer", 12'hF00, fint);
    wrb(RISPC_R_NUM_2, 8'hFF, 8'h3F);
    wrb(RISPC_R_NUM_1, 8'hFF, 8'hFF);
    wrb(RISPC_R_NUM_0, 8'hFF, 8'hFF);
    chk("numerator", 22'h3FFFFF, fnum);
    wrb(RISPC_R_DEN_2, 8'h00, 8'h00);
    wrb(RISPC_R_DEN_1, 8'h00, 8'h00);
    wrb(RISPC_R_DEN_0, 8'h00, 8'h01);
    chk("denominator", 22'h000001, fden);
    foreach (bufs[k]) begin
      wrb(RISPC_R_INBUF, bufs[k], bufs[k]);
      chk("inbuf_switches", bufs[k], iswitch);
    end
    wrb(RISPC_R_MUXCTL, 8'h50, 8'h50);
    chk("inbuf_type", 4'h5, itype);
  endtask
  // a low clock enable must hold every register, so a write in that time is lost
  task automatic t_freeze();
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(RISPC_R_CHANNEL_DIVIDER, 8'h5A);
    repeat (2) @(posedge core_clk);
    chk("frozen divider", 8'hFF, chdiv);
    clk_en <= 1'b1;
    rd(RISPC_R_CHANNEL_DIVIDER, rd_val);
    chk("frozen register", 8'hFF, rd_val);
  endtask
  task automatic t_auto();
    pri_run = 1'b0;
    wait_bit(0, 1'b1, "auto to secondary");
    pri_run = 1'b1;
    wait_bit(0, 1'b0, "auto back to primary");
    chk("secondary path", 1'b1, sec_path);
    wrb(RISPC_R_SWCTL, 8'h00, 8'h00);
    pri_run = 1'b0;
    wait_bit(0, 1'b1, "auto to secondary");
    pri_run = 1'b1;
    wait_bit(2, 1'b0, "secondary path dropped");
    // host keeps keep-alive set so later switchovers stay repeatable
    wrb(RISPC_R_SWCTL, 8'h04, 8'h04);
  endtask
  task automatic t_lost();
    pri_run = 1'b0;
    sec_run = 1'b0;
    wait_bit(1, 1'b1, "both_refs_lost");
    chk("pll outputs enable", 1'b0, outs_en);
    // the switch gap ends a few cycles after the loss flag rises
    wait_bit(0, 1'b1, "waits on secondary");
    rd(RISPC_R_STATUS, rd_val);
    chk("status", 8'h0C, rd_val);
    sec_run = 1'b1;
    wait_bit(1, 1'b0, "both_refs_lost");
    chk("stays on secondary", 1'b1, use_sec);
    chk("pll outputs enable", 1'b1, outs_en);
  endtask
  // primary stays dead here, so auto mode and manual primary give different answers
  task automatic t_modes();
    logic [1:0] sels [7] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0};
    logic [1:0] pins [7] = '{RISPC_PIN_LOW, RISPC_PIN_LOW, RISPC_PIN_LOW, RISPC_PIN_MID,
                             RISPC_PIN_HIGH, 2'h3, RISPC_PIN_LOW};
    logic       exps [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    for (int k = 0; k < 7; k++) begin
      @(posedge core_clk);
      ref_choice_pin <= pins[k];
      wrb(RISPC_R_MUXCTL, {6'h00, sels[k]}, {6'h00, sels[k]});
      wait_bit(0, exps[k], "mode select");
      repeat (16) @(posedge core_clk);
    end
    pri_run = 1'b1;
    wait_bit(0, 1'b0, "auto back to primary");
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // watchdog: the sequence needs a few hundred cycles
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    pri_run = 1'b1;
    sec_run = 1'b1;
    wait_bit(3, 1'b1, "outputs enable");
    // auto mode leaves for the secondary right after reset; let it come back first
    wait_bit(0, 1'b0, "settled on primary");
    t_cfg();
    t_freeze();
    t_auto();
    t_lost();
    t_modes();
    tally_and_finish();
  end
endmodule

// ### dv/rispc_top_sva.sv
// checker on the ports of the reference select block
`timescale 1ns/1ps
module rispc_top_chk
  import rispc_pkg::*;
#(
  parameter int LOSS_CYC = RISPC_LOSS_CYC
) (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        clk_en,
  input wire logic [6:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        ref_use_secondary,
  input wire logic        ref_gate_open,
  input wire logic        both_refs_lost,
  input wire logic        pll_outputs_enable,
  input wire logic [2:0]  ref_div_m1,
  input wire logic [11:0] fb_integer,
  input wire logic [21:0] fraction_denominator,
  input wire logic [3:0]  post_divider,
  input wire logic [7:0]  channel_divider_m1
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [1:0] sel_reg;
  logic [4:0] hold_reg;
  // shadow of the select field; hold counts cycles since it moved, so a switch gets time
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sel_reg  <= 2'h0;
      hold_reg <= 5'h00;
    end else if (clk_en && reg_wr && reg_addr == RISPC_R_MUXCTL) begin
      sel_reg  <= reg_wdata[1:0];
      hold_reg <= 5'h00;
    end else if (hold_reg != 5'h1F) begin
      hold_reg <= hold_reg + 5'h01;
    end
  end
  chk_rdata_idle_zero: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_lost_mutes_out: assert property (both_refs_lost |-> !pll_outputs_enable)
    else $error("outputs enabled while both references lost");
  chk_sec_div_one: assert property (ref_use_secondary [*3] |-> ref_div_m1 == 3'h0)
    else $error("reference divider not one on secondary");
  chk_post_in_range: assert property (post_divider >= 4'h2 && post_divider <= 4'h8)
    else $error("post divider outside two to eight");
  chk_int_nonzero: assert property (fb_integer != 12'h000)
    else $error("feedback integer is zero");
  chk_den_nonzero: assert property (fraction_denominator != 22'h000000)
    else $error("denominator is zero");
  chk_gap_before_switch: assert property ($changed(ref_use_secondary) |-> !$past(ref_gate_open))
    else $error("mux switched with gate open");
  chk_gate_reopens: assert property ($fell(ref_gate_open) |-> ##[1:12] ref_gate_open)
    else $error("gate stayed closed too long");
  chk_manual_pri_held: assert property (sel_reg == 2'h2 && hold_reg > 5'h0B |-> !ref_use_secondary)
    else $error("manual primary not on primary");
  chk_manual_sec_held: assert property (sel_reg == 2'h3 && hold_reg > 5'h0B |-> ref_use_secondary)
    else $error("manual secondary not on secondary");
  chk_channel_divider_follows: assert property (clk_en && reg_wr && reg_addr == RISPC_R_CHANNEL_DIVIDER
    |=> ##1 channel_divider_m1 == $past(reg_wdata, 2))
    else $error("channel divider did not follow write");
endmodule

bind rispc_top rispc_top_chk #(.LOSS_CYC(LOSS_CYC)) u_rispc_top_chk (
  .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_use_secondary(ref_use_secondary),
  .ref_gate_open(ref_gate_open), .both_refs_lost(both_refs_lost), .pll_outputs_enable(pll_outputs_enable),
  .ref_div_m1(ref_div_m1), .fb_integer(fb_integer), .fraction_denominator(fraction_denominator),
  .post_divider(post_divider), .channel_divider_m1(channel_divider_m1)
);

// ### logic/rispc_glitchless_mux.sv
// glitch-free reference switch: old source off, guard gap, then new source on
`timescale 1ns/1ps
module rispc_glitchless_mux
  import rispc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic clk_en,
  input  wire logic want_sec,
  output logic      use_sec,
  output logic      gate_open
);
  rispc_sel_e  st_reg;
  logic [3:0]  gap_reg;

  // a switch always passes through a closed gap, so no runt pulse reaches the pll
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_reg    <= RISPC_ST_PRI;
      gap_reg   <= 4'h0;
      use_sec   <= 1'b0;
      gate_open <= 1'b1;
    end else if (clk_en) begin
      case (st_reg)
        RISPC_ST_PRI, RISPC_ST_SEC: begin
          if (want_sec != use_sec) begin
            st_reg    <= RISPC_ST_GAP;
            gate_open <= 1'b0;
            gap_reg   <= 4'h0;
          end
        end
        RISPC_ST_GAP: begin
          if (gap_reg == 4'(RISPC_GUARD_CYC - 1)) begin
            use_sec   <= want_sec;
            gate_open <= 1'b1;
            st_reg    <= want_sec ? RISPC_ST_SEC : RISPC_ST_PRI;
          end else begin
            gap_reg <= gap_reg + 4'h1;
          end
        end
        default: begin
          st_reg <= RISPC_ST_PRI;
        end
      endcase
    end
  end
endmodule

// ### logic/rispc_pkg.sv
// package: register map, field positions, reset values and timing for the reference select block
package rispc_pkg;
  localparam int          RISPC_NUM_REGS      = 124;
  localparam int          RISPC_ADDR_W        = 7;
  // register numbers (byte-wide registers)
  localparam logic [6:0]  RISPC_R_PLLDIV_A    = 7'h18; // [2:0] ref divider-1, [3] doubler, [4] keep secondary
  localparam logic [6:0]  RISPC_R_PRESC       = 7'h19; // [4:0] prescaler-1
  localparam logic [6:0]  RISPC_R_POSTDIV     = 7'h1A; // [3:0] post-divider value
  localparam logic [6:0]  RISPC_R_CHANNEL_DIVIDER      = 7'h1B; // [7:0] channel divider-1
  localparam logic [6:0]  RISPC_R_OUTSEL      = 7'h1C; // [0] output source, 1 = pll
  localparam logic [6:0]  RISPC_R_INBUF       = 7'h1D; // [5:0] bias/termination switches
  localparam logic [6:0]  RISPC_R_INT_HI      = 7'h1E; // [3:0] integer bits 11:8
  localparam logic [6:0]  RISPC_R_INT_LO      = 7'h1F;
  localparam logic [6:0]  RISPC_R_NUM_2       = 7'h20; // [5:0] numerator bits 21:16
  localparam logic [6:0]  RISPC_R_NUM_1       = 7'h21;
  localparam logic [6:0]  RISPC_R_NUM_0       = 7'h22;
  localparam logic [6:0]  RISPC_R_DEN_2       = 7'h23;
  localparam logic [6:0]  RISPC_R_DEN_1       = 7'h24;
  localparam logic [6:0]  RISPC_R_DEN_0       = 7'h25;
  localparam logic [6:0]  RISPC_R_STATUS      = 7'h26; // read only
  localparam logic [6:0]  RISPC_R_MUXCTL      = 7'h32; // [1:0] select, [7:4] buffer type
  localparam logic [6:0]  RISPC_R_SWCTL       = 7'h33; // [2] keep-alive
  // field positions
  localparam int          RISPC_B_DOUBLER     = 3;
  localparam int          RISPC_B_KEEPALIVE   = 2;
  // reset values
  localparam logic [7:0]  RISPC_RST_ZERO      = 8'h00;
  localparam logic [11:0] RISPC_RST_INT       = 12'h001;
  localparam logic [21:0] RISPC_RST_DEN       = 22'h000001;
  localparam logic [3:0]  RISPC_RST_POST      = 4'h2;
  localparam logic [3:0]  RISPC_POST_MIN      = 4'h2;
  localparam logic [3:0]  RISPC_POST_MAX      = 4'h8;
  localparam logic [7:0]  RISPC_RST_SWCTL     = 8'h04;
  // availability monitor timing and switch guard gap
  localparam int          RISPC_CLK_MHZ       = 125;
  localparam int          RISPC_LOSS_TIME_NS  = 400;
  localparam int          RISPC_LOSS_CYC      = (RISPC_LOSS_TIME_NS * RISPC_CLK_MHZ) / 1000;
  localparam int          RISPC_GUARD_CYC     = 4;
  // three-level select pin encoding
  localparam logic [1:0]  RISPC_PIN_LOW       = 2'h0;
  localparam logic [1:0]  RISPC_PIN_MID       = 2'h1;
  localparam logic [1:0]  RISPC_PIN_HIGH      = 2'h2;
  typedef enum logic [1:0] {
    RISPC_ST_PRI  = 2'h0,
    RISPC_ST_GAP  = 2'h1,
    RISPC_ST_SEC  = 2'h2
  } rispc_sel_e;
endpackage

// ### logic/rispc_ref_monitor.sv
// reference availability monitor: a reference is lost when its edge activity stalls
`timescale 1ns/1ps
module rispc_ref_monitor
  import rispc_pkg::*;
#(
  parameter int LOSS_CYC = RISPC_LOSS_CYC
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic clk_en,
  input  wire logic ref_sample,
  output logic      ref_ok
);
  logic [15:0] idle_reg;
  logic        last_reg;

  // count cycles since the last edge of the sampled reference
  always_ff @(posedge core_clk) begin
    if (srst) begin
      idle_reg <= 16'h0000;
      last_reg <= 1'b0;
      ref_ok   <= 1'b0;
    end else if (clk_en) begin
      last_reg <= ref_sample;
      if (ref_sample != last_reg) begin
        idle_reg <= 16'h0000;
        ref_ok   <= 1'b1;
      end else if (idle_reg >= 16'(LOSS_CYC)) begin
        ref_ok   <= 1'b0;
      end else begin
        idle_reg <= idle_reg + 16'h0001;
      end
    end
  end
endmodule

// ### logic/rispc_top.sv
// reference input selection, loss indication and pll divider configuration registers
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - 124 byte registers, numbered from zero
// - bits named register dot bit position
// - vco from ref, R, D, int+frac, M
// - feedback integer 12 bits, 1 to 4095
// - numerator and denominator 22 bits each
// - ref divider 1..8, one on secondary
// - prescaler 5 bits, divide 1..32
// - doubler gives one or two
// - channel divider 8 bits, 1..256
// - post-divider only two through eight
// - switching between references is glitch free
// - auto mode leaves lost primary
// - auto mode returns to recovered primary
// - both lost: wait on secondary
// - both lost: loss flag, outputs disabled
// - select field and three-level pin decode
// - no keep-alive: drop secondary after return
// - bias bit per input for ac coupling
// - buffer type and termination patterns
module rispc_top
  import rispc_pkg::*;
#(
  parameter int LOSS_CYC = RISPC_LOSS_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        primary_reference,
  input  wire logic        secondary_reference,
  input  wire logic [1:0]  ref_choice_pin,
  output logic             ref_use_secondary,
  output logic             ref_gate_open,
  output logic             both_refs_lost,
  output logic             pll_outputs_enable,
  output logic             secondary_path_enable,
  output logic [2:0]       ref_div_m1,
  output logic             doubler_en,
  output logic [11:0]      fb_integer,
  output logic [21:0]      fb_numerator,
  output logic [21:0]      fraction_denominator,
  output logic [4:0]       prescale_m1,
  output logic [3:0]       post_divider,
  output logic [7:0]       channel_divider_m1,
  output logic             output_source_selector,
  output logic [5:0]       inbuf_switches,
  output logic [3:0]       inbuf_type
);
  logic [7:0]  plldiv_reg;
  logic [7:0]  presc_reg;
  logic [7:0]  channel_divider_reg;
  logic [7:0]  outsel_reg;
  logic [7:0]  inbuf_reg;
  logic [7:0]  muxctl_reg;
  logic [7:0]  swctl_reg;
  logic [3:0]  post_reg;
  logic [11:0] int_reg;
  logic [21:0] num_reg;
  logic [21:0] den_reg;
  logic        pri_ok;
  logic        sec_ok;
  logic        want_sec;
  logic        auto_mode;
  logic        manual_sec;
  logic        mux_sec;
  logic        mux_open;
  logic        ever_sec_reg;
  logic        sec_off_reg;

  // register number n maps straight to address n, byte wide
  function automatic logic in_map(input logic [6:0] a);
    in_map = (7'(a) < 7'(RISPC_NUM_REGS));
  endfunction

  // integer field: zero is not a legal divide, keep old value
  function automatic logic [11:0] int_fix(input logic [11:0] cur, input logic [11:0] nv);
    int_fix = (nv == 12'h000) ? cur : nv;
  endfunction

  // write side of the configuration registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      plldiv_reg <= RISPC_RST_ZERO;
      presc_reg  <= RISPC_RST_ZERO;
      channel_divider_reg <= RISPC_RST_ZERO;
      outsel_reg <= RISPC_RST_ZERO;
      inbuf_reg  <= RISPC_RST_ZERO;
      muxctl_reg <= RISPC_RST_ZERO;
      swctl_reg  <= RISPC_RST_SWCTL;
    end else if (clk_en && reg_wr && in_map(reg_addr)) begin
      case (reg_addr)
        RISPC_R_PLLDIV_A: plldiv_reg <= reg_wdata & 8'h1F;
        RISPC_R_PRESC:    presc_reg  <= reg_wdata & 8'h1F;
        RISPC_R_CHANNEL_DIVIDER:   channel_divider_reg <= reg_wdata;
        RISPC_R_OUTSEL:   outsel_reg <= reg_wdata & 8'h01;
        RISPC_R_INBUF:    inbuf_reg  <= reg_wdata & 8'h3F;
        RISPC_R_MUXCTL:   muxctl_reg <= reg_wdata & 8'hF3;
        RISPC_R_SWCTL:    swctl_reg  <= reg_wdata & 8'h04;
        default: begin
        end
      endcase
    end
  end

  // post-divider accepts only 2..8, other writes are dropped
  always_ff @(posedge core_clk) begin
    if (srst) begin
      post_reg <= RISPC_RST_POST;
    end else if (clk_en && reg_wr && reg_addr == RISPC_R_POSTDIV) begin
      if (reg_wdata[3:0] >= RISPC_POST_MIN && reg_wdata[3:0] <= RISPC_POST_MAX && reg_wdata[7:4] == 4'h0) begin
        post_reg <= reg_wdata[3:0];
      end
    end
  end

  // feedback integer and fraction, split over byte registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      int_reg <= RISPC_RST_INT;
      num_reg <= 22'h000000;
      den_reg <= RISPC_RST_DEN;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        RISPC_R_INT_HI: int_reg <= int_fix(int_reg, {reg_wdata[3:0], int_reg[7:0]});
        RISPC_R_INT_LO: int_reg <= int_fix(int_reg, {int_reg[11:8], reg_wdata});
        RISPC_R_NUM_2:  num_reg <= {reg_wdata[5:0], num_reg[15:0]};
        RISPC_R_NUM_1:  num_reg <= {num_reg[21:16], reg_wdata, num_reg[7:0]};
        RISPC_R_NUM_0:  num_reg <= {num_reg[21:8], reg_wdata};
        // a zero denominator would make the fraction undefined, so the old value stays
        RISPC_R_DEN_2: begin
          if ({reg_wdata[5:0], den_reg[15:0]} != 22'h0) begin
            den_reg <= {reg_wdata[5:0], den_reg[15:0]};
          end
        end
        RISPC_R_DEN_1: begin
          if ({den_reg[21:16], reg_wdata, den_reg[7:0]} != 22'h0) begin
            den_reg <= {den_reg[21:16], reg_wdata, den_reg[7:0]};
          end
        end
        RISPC_R_DEN_0: begin
          if ({den_reg[21:8], reg_wdata} != 22'h0) begin
            den_reg <= {den_reg[21:8], reg_wdata};
          end
        end
        default: begin
        end
      endcase
    end
  end

  // read data valid one cycle after the strobe only; unmapped reads give zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd && in_map(reg_addr)) begin
        case (reg_addr)
          RISPC_R_PLLDIV_A: reg_rdata <= plldiv_reg;
          RISPC_R_PRESC:    reg_rdata <= presc_reg;
          RISPC_R_POSTDIV:  reg_rdata <= {4'h0, post_reg};
          RISPC_R_CHANNEL_DIVIDER:   reg_rdata <= channel_divider_reg;
          RISPC_R_OUTSEL:   reg_rdata <= outsel_reg;
          RISPC_R_INBUF:    reg_rdata <= inbuf_reg;
          RISPC_R_INT_HI:   reg_rdata <= {4'h0, int_reg[11:8]};
          RISPC_R_INT_LO:   reg_rdata <= int_reg[7:0];
          RISPC_R_NUM_2:    reg_rdata <= {2'h0, num_reg[21:16]};
          RISPC_R_NUM_1:    reg_rdata <= num_reg[15:8];
          RISPC_R_NUM_0:    reg_rdata <= num_reg[7:0];
          RISPC_R_DEN_2:    reg_rdata <= {2'h0, den_reg[21:16]};
          RISPC_R_DEN_1:    reg_rdata <= den_reg[15:8];
          RISPC_R_DEN_0:    reg_rdata <= den_reg[7:0];
          RISPC_R_STATUS:   reg_rdata <= {3'h0, sec_off_reg, both_refs_lost, ref_use_secondary, sec_ok, pri_ok};
          RISPC_R_MUXCTL:   reg_rdata <= muxctl_reg;
          RISPC_R_SWCTL:    reg_rdata <= swctl_reg;
          default:          reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // one activity monitor per reference
  rispc_ref_monitor #(.LOSS_CYC(LOSS_CYC)) u_pri_mon (
    .core_clk   (core_clk),
    .srst       (srst),
    .clk_en     (clk_en),
    .ref_sample (primary_reference),
    .ref_ok     (pri_ok)
  );
  rispc_ref_monitor #(.LOSS_CYC(LOSS_CYC)) u_sec_mon (
    .core_clk   (core_clk),
    .srst       (srst),
    .clk_en     (clk_en),
    .ref_sample (secondary_reference),
    .ref_ok     (sec_ok)
  );

  // mode decode from the two select bits and the three-level pin
  always_comb begin
    auto_mode  = 1'b0;
    manual_sec = 1'b0;
    case (muxctl_reg[1:0])
      2'h0: auto_mode = 1'b1;
      2'h1: begin
        auto_mode  = (ref_choice_pin == RISPC_PIN_HIGH);
        manual_sec = (ref_choice_pin == RISPC_PIN_MID);
      end
      2'h2: manual_sec = 1'b0;
      default: manual_sec = 1'b1;
    endcase
  end

  // auto: leave a dead primary, come back when it returns, park on secondary if both are dead
  always_comb begin
    if (auto_mode) begin
      want_sec = !pri_ok;
    end else begin
      want_sec = manual_sec;
    end
  end

  rispc_glitchless_mux u_mux (
    .core_clk  (core_clk),
    .srst      (srst),
    .clk_en    (clk_en),
    .want_sec  (want_sec),
    .use_sec   (mux_sec),
    .gate_open (mux_open)
  );

  // one-shot return: drop the secondary path once back on primary without keep-alive
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ever_sec_reg <= 1'b0;
      sec_off_reg  <= 1'b0;
    end else if (clk_en) begin
      if (mux_sec) begin
        ever_sec_reg <= 1'b1;
      end
      if (swctl_reg[RISPC_B_KEEPALIVE] || !auto_mode) begin
        sec_off_reg <= 1'b0;
      end else if (ever_sec_reg && !mux_sec && mux_open) begin
        sec_off_reg <= 1'b1;
      end
    end
  end

  // status and mux outputs, each from a flip-flop
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ref_use_secondary     <= 1'b0;
      ref_gate_open         <= 1'b0;
      both_refs_lost        <= 1'b0;
      pll_outputs_enable    <= 1'b0;
      secondary_path_enable <= 1'b1;
    end else if (clk_en) begin
      ref_use_secondary     <= mux_sec;
      ref_gate_open         <= mux_open;
      both_refs_lost        <= !pri_ok && !sec_ok;
      pll_outputs_enable    <= pri_ok || sec_ok;
      secondary_path_enable <= !sec_off_reg;
    end
  end

  // divider fields to the analog side; R forced to one on secondary
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ref_div_m1             <= 3'h0;
      doubler_en             <= 1'b0;
      fb_integer             <= RISPC_RST_INT;
      fb_numerator           <= 22'h000000;
      fraction_denominator   <= RISPC_RST_DEN;
      prescale_m1            <= 5'h00;
      post_divider           <= RISPC_RST_POST;
      channel_divider_m1     <= 8'h00;
      output_source_selector <= 1'b0;
      inbuf_switches         <= 6'h00;
      inbuf_type             <= 4'h0;
    end else if (clk_en) begin
      ref_div_m1             <= mux_sec ? 3'h0 : plldiv_reg[2:0];
      doubler_en             <= plldiv_reg[RISPC_B_DOUBLER];
      fb_integer             <= int_reg;
      fb_numerator           <= num_reg;
      fraction_denominator   <= den_reg;
      prescale_m1            <= presc_reg[4:0];
      post_divider           <= post_reg;
      channel_divider_m1     <= channel_divider_reg;
      output_source_selector <= outsel_reg[0];
      inbuf_switches         <= inbuf_reg[5:0];
      inbuf_type             <= muxctl_reg[7:4];
    end
  end
endmodule
